// ### pkg/ssr_defines.vh
/*
 * Offsets, field positions, reset values and codes for the state store and
 * service request block. Assumes a 32-bit AXI4-Lite register bus.
 */
`ifndef SSR_DEFINES_VH
`define SSR_DEFINES_VH
`define SSR_OFF_CMD        8'h00
`define SSR_OFF_CMD_ARG    8'h04
`define SSR_OFF_STATUS     8'h08
`define SSR_OFF_STB        8'h0c
`define SSR_OFF_SRE        8'h10
`define SSR_OFF_ESE        8'h14
`define SSR_OFF_PSC        8'h18
`define SSR_OFF_OUTQ       8'h1c
`define SSR_OFF_OPTIONS    8'h20
`define SSR_OFF_SETTING    8'h24
`define SSR_OFF_INPUTS     8'h28
`define SSR_OFF_SNAP_DATA  8'h2c
`define SSR_CMD_OPCQ       4'h1
`define SSR_CMD_OPTQ       4'h2
`define SSR_CMD_SAV        4'h3
`define SSR_CMD_RCL        4'h4
`define SSR_CMD_RST        4'h5
`define SSR_CMD_TRG        4'h6
`define SSR_CMD_DCL        4'h7
`define SSR_CMD_SPOLL      4'h8
`define SSR_CMD_SETREG     4'h9
`define SSR_STB_OPER       7
`define SSR_STB_MSS        6
`define SSR_STB_ESB        5
`define SSR_STB_MAV        4
`define SSR_STB_QUES       3
`define SSR_ASCII_ONE      8'h31
`define SSR_SET_WIDTH      32
`define SSR_SET_OUTPUT     0
`define SSR_SET_RELAY      1
`define SSR_SET_CAL_AUTO   2
`define SSR_SET_PROT       3
`define SSR_SET_CONT_INIT  4
`define SSR_SET_CURR_MODE  5
`define SSR_SET_VOLT_MODE  6
`define SSR_SET_DISPLAY    7
`define SSR_SET_TRG_LINE   8
`define SSR_SET_FAULT_IND  9
`define SSR_SET_TRIG_SRC   11:10
`define SSR_SET_LIST_CNT   15:12
`define SSR_SET_PROT_DLY   19:16
`define SSR_SET_TRIG_DLY   23:20
`define SSR_SET_VOLT_LVL   27:24
`define SSR_SET_OVP_LVL    31:28
`define SSR_RST_SETTING    32'hf000_1180
`define SSR_NV_SNAPS       5
`define SSR_SNAPS          10
`endif

// ### src/ssr_nv_store.v
/*
 * Nonvolatile backing store model of registers: enable masks, power-on clear
 * setting and snapshots 0 to 4. Contents hold across srst, standing for
 * power loss. Assumes writes are single-cycle pulses on clk_sys.
 */
`timescale 1ns/1ns
`include "ssr_defines.vh"
module ssr_nv_store #(
    parameter WIDTH = 32,
    parameter DEPTH = 5
)(
    input  wire             clk_sys,
    input  wire             mask_we,
    input  wire [7:0]       sre_in,
    input  wire [7:0]       ese_in,
    input  wire             psc_we,
    input  wire             psc_in,
    input  wire             snap_we,
    input  wire [2:0]       snap_waddr,
    input  wire [WIDTH-1:0] snap_wdata,
    input  wire [2:0]       snap_raddr,
    output wire [WIDTH-1:0] snap_rdata,
    output wire [7:0]       sre_out,
    output wire [7:0]       ese_out,
    output wire             psc_out,
    output reg  [15:0]      write_count_reg
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [7:0]       sre_nv_reg;
    reg [7:0]       ese_nv_reg;
    reg             psc_nv_reg;
    integer         i;

    initial
    begin
        for (i = 0; i < DEPTH; i = i + 1)
            mem[i] = `SSR_RST_SETTING;
        sre_nv_reg = 8'h00;
        ese_nv_reg = 8'h00;
        psc_nv_reg = 1'b1;
        write_count_reg = 16'h0000;
    end

    always @(posedge clk_sys)
    begin
        if (mask_we)
        begin
            sre_nv_reg <= sre_in;
            ese_nv_reg <= ese_in;
        end
        if (psc_we)
            psc_nv_reg <= psc_in;
        if (snap_we)
            mem[snap_waddr] <= snap_wdata;
        if (mask_we || psc_we || snap_we)
            write_count_reg <= write_count_reg + 16'h0001;
    end

    assign snap_rdata = mem[snap_raddr];
    assign sre_out    = sre_nv_reg;
    assign ese_out    = ese_nv_reg;
    assign psc_out    = psc_nv_reg;
endmodule

// ### src/ssr_top.v
/*
 * State store and service request block: operation-complete query, options
 * query, power-on status clear, save and recall of ten snapshots, reset
 * defaults and the service-request mask, all behind an AXI4-Lite slave.
 * Assumes a command parser writes commands into the command register.
 */
// Functional notes
// - Operation-complete query queues ASCII one once all pending work finishes.
// - Commands after an outstanding operation-complete query wait until work finishes.
// - A trigger after that query blocks commands; only device clear restores.
// - Options query returns installed option numbers, zero when none fitted.
// - Non-zero power-on clear setting clears both enable masks at power-up.
// - Zero power-on clear setting restores both masks from storage at power-up.
// - Power-on clear writes persist; mask writes persist while that setting is zero.
// - Recall reloads every saved setting from locations zero through nine.
// - Recall first aborts all uncompleted trigger actions.
// - Recall turns calibration mode off.
// - Power-up auto-recalls location zero when the configuration switch says so.
// - Power-up copies location zero into volatile locations five through nine.
// - Reset aborts triggers and loads factory defaults.
// - Save stores settings in ten locations; zero to four survive power loss.
// - Enabled status bits ORed drive bit six, summary and service request.
// - Serial poll clears service request indication, leaves summary bit.
// - Zero service-request mask never asserts a service request.
// - Status byte fixed layout; bits two to zero read zero.
// - Pending work finishes when commands, settling and triggers are all done.
`timescale 1ns/1ns
`include "ssr_defines.vh"
module ssr_top #(
    parameter [7:0] OPTIONS_CODE = 8'h00
)(
    input  wire        clk_sys,
    input  wire        srst,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        config_switch_pin,
    input  wire        ops_done_pin,
    output reg         trigger_abort_reg,
    output reg         cal_mode_reg,
    output reg         srq_reg,
    output reg  [31:0] setting_out_reg
);
    localparam ST_IDLE  = 4'b0001;
    localparam ST_WAIT  = 4'b0010;
    localparam ST_STUCK = 4'b0100;
    localparam ST_BOOT  = 4'b1000;

    reg  [3:0]  state_reg;
    reg  [2:0]  boot_idx_reg;
    reg         sw_meta_reg;
    reg         sw_sync_reg;
    reg         done_meta_reg;
    reg         done_sync_reg;
    reg  [31:0] setting_reg;
    reg  [31:0] vol_snap [0:4];
    reg  [7:0]  sre_reg;
    reg  [7:0]  ese_reg;
    reg         psc_reg;
    reg         rqs_reg;
    reg         mss_prev_reg;
    reg         mav_reg;
    reg  [7:0]  outq_reg;
    reg  [3:0]  pend_cmd_reg;
    reg  [3:0]  pend_arg_reg;
    reg         pend_valid_reg;
    reg  [3:0]  cmd_arg_reg;
    reg  [4:0]  sum_bits_reg;
    reg  [7:0]  aw_addr_reg;
    reg         aw_have_reg;
    reg  [31:0] w_data_reg;
    reg         w_have_reg;
    reg         mask_we;
    reg         psc_we;
    reg         snap_we;
    reg  [2:0]  snap_raddr;
    wire [31:0] nv_rdata;
    wire [7:0]  nv_sre;
    wire [7:0]  nv_ese;
    wire        nv_psc;
    wire [15:0] nv_writes;
    wire        wr_go;
    wire        is_cmd_wr;
    wire [3:0]  cmd_code;
    wire [7:0]  stb_val;
    wire        mss;
    wire [31:0] snap_sel;

    // Status byte layout.
    // fixed bit layout
    assign stb_val = {sum_bits_reg[4], mss, sum_bits_reg[3], mav_reg, sum_bits_reg[2], 3'b000};
    assign mss = |({sum_bits_reg[4], 1'b0, sum_bits_reg[3], mav_reg, sum_bits_reg[2], 3'b000} & sre_reg);

    assign wr_go     = aw_have_reg && w_have_reg && !s_axi_bvalid;
    assign is_cmd_wr = wr_go && (aw_addr_reg == `SSR_OFF_CMD);
    assign cmd_code  = w_data_reg[3:0];
    assign snap_sel  = vol_snap[pend_arg_reg[2:0] - 3'd5];

    ssr_nv_store #(
        .WIDTH (`SSR_SET_WIDTH),
        .DEPTH (`SSR_NV_SNAPS)
    ) u_nv (
        .clk_sys         (clk_sys),
        .mask_we         (mask_we),
        .sre_in          (aw_addr_reg == `SSR_OFF_SRE ? w_data_reg[7:0] : sre_reg),
        .ese_in          (aw_addr_reg == `SSR_OFF_SRE ? ese_reg : w_data_reg[7:0]),
        .psc_we          (psc_we),
        .psc_in          (|w_data_reg),
        .snap_we         (snap_we),
        .snap_waddr      (pend_arg_reg[2:0]),
        .snap_wdata      (setting_reg),
        .snap_raddr      (snap_raddr),
        .snap_rdata      (nv_rdata),
        .sre_out         (nv_sre),
        .ese_out         (nv_ese),
        .psc_out         (nv_psc),
        .write_count_reg (nv_writes)
    );

    // Nonvolatile write strobes and read address.
    always @*
    begin
        psc_we     = wr_go && aw_addr_reg == `SSR_OFF_PSC;
        mask_we    = wr_go && !psc_reg && (aw_addr_reg == `SSR_OFF_SRE || aw_addr_reg == `SSR_OFF_ESE);
        snap_we    = state_reg == ST_IDLE && pend_valid_reg && pend_cmd_reg == `SSR_CMD_SAV && pend_arg_reg < 4'd5;
        snap_raddr = state_reg == ST_BOOT ? 3'd0 : pend_arg_reg[2:0];
    end

    // Pin synchronisers.
    always @(posedge clk_sys)
    begin
        sw_meta_reg   <= config_switch_pin;
        sw_sync_reg   <= sw_meta_reg;
        done_meta_reg <= ops_done_pin;
        done_sync_reg <= done_meta_reg;
    end

    // AXI4-Lite slave channels.
    always @(posedge clk_sys)
    begin
        if (srst)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= 2'b00;
            s_axi_rdata   <= 32'h0000_0000;
            aw_have_reg   <= 1'b0;
            w_have_reg    <= 1'b0;
            aw_addr_reg   <= 8'h00;
            w_data_reg    <= 32'h0000_0000;
        end
        else
        begin
            s_axi_awready <= !aw_have_reg && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_have_reg && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
            end
            if (wr_go && (!is_cmd_wr || !pend_valid_reg))
            begin
                aw_have_reg  <= 1'b0;
                w_have_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr_reg > `SSR_OFF_SNAP_DATA || aw_addr_reg[1:0] != 2'b00) ? 2'b10 : 2'b00;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= 2'b00;
                if (s_axi_araddr == `SSR_OFF_STATUS)
                    s_axi_rdata <= {24'h0, nv_writes[3:0], state_reg};
                else if (s_axi_araddr == `SSR_OFF_CMD_ARG)
                    s_axi_rdata <= {28'h0, cmd_arg_reg};
                else if (s_axi_araddr == `SSR_OFF_STB)
                    s_axi_rdata <= {24'h0, stb_val};
                else if (s_axi_araddr == `SSR_OFF_SRE)
                    s_axi_rdata <= {24'h0, sre_reg};
                else if (s_axi_araddr == `SSR_OFF_ESE)
                    s_axi_rdata <= {24'h0, ese_reg};
                else if (s_axi_araddr == `SSR_OFF_PSC)
                    s_axi_rdata <= {31'h0, psc_reg};
                else if (s_axi_araddr == `SSR_OFF_OUTQ)
                    s_axi_rdata <= {23'h0, mav_reg, outq_reg};
                else if (s_axi_araddr == `SSR_OFF_OPTIONS)
                    s_axi_rdata <= {24'h0, OPTIONS_CODE};
                else if (s_axi_araddr == `SSR_OFF_SETTING)
                    s_axi_rdata <= setting_reg;
                else if (s_axi_araddr == `SSR_OFF_INPUTS)
                    s_axi_rdata <= {27'h0, sum_bits_reg};
                else if (s_axi_araddr == `SSR_OFF_CMD)
                    s_axi_rdata <= {28'h0, pend_cmd_reg};
                else
                begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'b10;
                end
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // Command engine and state.
    always @(posedge clk_sys)
    begin
        trigger_abort_reg <= 1'b0;
        setting_out_reg   <= setting_reg;
        srq_reg           <= rqs_reg;
        mss_prev_reg      <= mss;
        if (srst)
        begin
            state_reg      <= ST_BOOT;
            boot_idx_reg   <= 3'd0;
            sre_reg        <= 8'h00;
            ese_reg        <= 8'h00;
            psc_reg        <= 1'b1;
            rqs_reg        <= 1'b0;
            mav_reg        <= 1'b0;
            outq_reg       <= 8'h00;
            pend_valid_reg <= 1'b0;
            pend_cmd_reg   <= 4'h0;
            pend_arg_reg   <= 4'h0;
            cmd_arg_reg    <= 4'h0;
            sum_bits_reg   <= 5'h00;
            cal_mode_reg   <= 1'b0;
            setting_reg    <= `SSR_RST_SETTING;
            srq_reg        <= 1'b0;
        end
        else
        begin
            if (wr_go && aw_addr_reg == `SSR_OFF_CMD_ARG)
                cmd_arg_reg <= w_data_reg[3:0];
            if (wr_go && aw_addr_reg == `SSR_OFF_INPUTS)
                sum_bits_reg <= w_data_reg[4:0];
            if (wr_go && aw_addr_reg == `SSR_OFF_SETTING)
                setting_reg <= w_data_reg;
            if (wr_go && aw_addr_reg == `SSR_OFF_SRE)
                sre_reg <= w_data_reg[7:0];
            if (wr_go && aw_addr_reg == `SSR_OFF_ESE)
                ese_reg <= w_data_reg[7:0];
            if (wr_go && aw_addr_reg == `SSR_OFF_PSC)
                psc_reg <= |w_data_reg;
            if (wr_go && aw_addr_reg == `SSR_OFF_SNAP_DATA)
                cal_mode_reg <= w_data_reg[0];
            // zero mask gives no request
            // Only a fresh rise of the summary raises the request, so a poll's clear sticks.
            if (mss && !mss_prev_reg && sre_reg != 8'h00 && !(wr_go && aw_addr_reg == `SSR_OFF_STB))
                rqs_reg <= 1'b1;
            else if (is_cmd_wr && cmd_code == `SSR_CMD_SPOLL)
                rqs_reg <= 1'b0;
            if (!mss)
                rqs_reg <= 1'b0;
            if (wr_go && aw_addr_reg == `SSR_OFF_OUTQ)
                mav_reg <= 1'b0;
            if (is_cmd_wr && !pend_valid_reg && cmd_code != `SSR_CMD_SPOLL)
            begin
                pend_valid_reg <= 1'b1;
                pend_cmd_reg   <= cmd_code;
                pend_arg_reg   <= cmd_arg_reg;
            end
            case (state_reg)
                ST_BOOT:
                begin
                    if (boot_idx_reg == 3'd0)
                    begin
                        psc_reg <= nv_psc;
                        sre_reg <= nv_psc ? 8'h00 : nv_sre;
                        ese_reg <= nv_psc ? 8'h00 : nv_ese;
                        if (sw_sync_reg)
                            setting_reg <= nv_rdata;
                        trigger_abort_reg <= 1'b1;
                    end
                    else
                        vol_snap[boot_idx_reg - 3'd1] <= nv_rdata;
                    boot_idx_reg <= boot_idx_reg + 3'd1;
                    if (boot_idx_reg == 3'd5)
                        state_reg <= ST_IDLE;
                end
                ST_WAIT:
                begin
                    if (is_cmd_wr && !pend_valid_reg && cmd_code == `SSR_CMD_TRG)
                        state_reg <= ST_STUCK;
                    else if (done_sync_reg)
                    begin
                        outq_reg  <= `SSR_ASCII_ONE;
                        mav_reg   <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                    if (pend_valid_reg && pend_cmd_reg == `SSR_CMD_DCL)
                    begin
                        pend_valid_reg <= 1'b0;
                        state_reg      <= ST_IDLE;
                    end
                end
                ST_STUCK:
                begin
                    if (pend_valid_reg && pend_cmd_reg == `SSR_CMD_DCL)
                    begin
                        pend_valid_reg <= 1'b0;
                        state_reg      <= ST_IDLE;
                    end
                    else if (pend_valid_reg)
                        pend_valid_reg <= 1'b0;
                end
                default:
                begin
                    if (pend_valid_reg)
                    begin
                        pend_valid_reg <= 1'b0;
                        case (pend_cmd_reg)
                            `SSR_CMD_OPCQ:
                                state_reg <= ST_WAIT;
                            `SSR_CMD_OPTQ:
                            begin
                                outq_reg <= OPTIONS_CODE;
                                mav_reg  <= 1'b1;
                            end
                            `SSR_CMD_SAV:
                                if (pend_arg_reg >= 4'd5 && pend_arg_reg <= 4'd9)
                                    vol_snap[pend_arg_reg[2:0] - 3'd5] <= setting_reg;
                            `SSR_CMD_RCL:
                                if (pend_arg_reg <= 4'd9)
                                begin
                                    trigger_abort_reg <= 1'b1;
                                    cal_mode_reg      <= 1'b0;
                                    setting_reg       <= pend_arg_reg < 4'd5 ? nv_rdata : snap_sel;
                                end
                            `SSR_CMD_RST:
                            begin
                                trigger_abort_reg <= 1'b1;
                                cal_mode_reg      <= 1'b0;
                                setting_reg       <= `SSR_RST_SETTING;
                            end
                            default:
                                cal_mode_reg <= cal_mode_reg;
                        endcase
                    end
                end
            endcase
        end
    end
endmodule

// ### tb/ssr_ops_model.sv
/*
 * Model of the output stage that reports when pending work has finished.
 * Assumes the bench raises busy while overlapped work is in progress.
 */
`timescale 1ns/1ns
module ssr_ops_model (
    input  wire  clk_sys,
    input  wire  busy,
    output logic ops_done_pin
);
    logic [2:0] settle_reg = 3'h7;
    // settling before done
    // Done rises only after the output has settled for three cycles.
    always @(posedge clk_sys)
    begin
        settle_reg <= {settle_reg[1:0], ~busy};
    end
    assign ops_done_pin = &settle_reg;
endmodule

// ### tb/ssr_top_properties.sv
/*
 * Bus and status checks for the state store block.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ns
`include "ssr_defines.vh"
module ssr_props #(
    parameter [7:0] OPTIONS_CODE = 8'h00
)(
    input wire        clk_sys,
    input wire        srst,
    input wire [7:0]  s_axi_awaddr,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [7:0]  s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        trigger_abort_reg,
    input wire        srq_reg
);
    logic [7:0] wa_q;
    logic [7:0] ra_q;
    wire        wa_bad = (wa_q > 8'h2c) || (wa_q[1:0] != 2'b00);
    wire        ra_bad = (ra_q > 8'h2c) || (ra_q[1:0] != 2'b00);
    always @(posedge clk_sys)
    begin
        if (s_axi_awvalid && s_axi_awready) wa_q <= s_axi_awaddr;
        if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    sequence rd_taken; s_axi_arvalid && s_axi_arready; endsequence
    sequence stb_ans; s_axi_rvalid && (ra_q == `SSR_OFF_STB); endsequence
    AST_STB_LOW_ZERO: assert property (stb_ans |-> s_axi_rdata[2:0] == 3'h0)
        else $error("status byte low bits not zero");
    AST_SRQ_HAS_MSS: assert property (stb_ans ##0 srq_reg |-> s_axi_rdata[6])
        else $error("service request without summary bit");
    AST_NO_SRQ_MASK0: assert property (s_axi_rvalid && ra_q == `SSR_OFF_SRE && s_axi_rdata[7:0] == 8'h00 |-> !srq_reg)
        else $error("service request with zero mask");
    AST_OPT_CODE: assert property (s_axi_rvalid && ra_q == `SSR_OFF_OPTIONS |-> s_axi_rdata[7:0] == OPTIONS_CODE)
        else $error("options value wrong");
    AST_ABORT_PULSE: assert property ($rose(trigger_abort_reg) |=> !trigger_abort_reg)
        else $error("abort not a single pulse");
    AST_WR_REFUSE: assert property (s_axi_bvalid && wa_bad |-> s_axi_bresp == 2'b10)
        else $error("unmapped write not refused");
    AST_RD_REFUSE: assert property (s_axi_rvalid && ra_bad |-> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    AST_RD_LAT: assert property (rd_taken |-> ##[1:3] s_axi_rvalid)
        else $error("read answer late");
endmodule
bind ssr_top ssr_props #(.OPTIONS_CODE(OPTIONS_CODE)) u_props (.*);

// ### tb/tb_state_store_and_service_request.sv
/*
 * Self-checking bench driving the block over AXI4-Lite.
 * Assumes the ops model stands for the output stage.
 */
`timescale 1ns/1ns
`include "ssr_defines.vh"
module tb_state_store_and_service_request;
    logic clk_sys = 1'b0, srst = 1'b1, busy = 1'b0, cfg = 1'b0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, ops_done, abort, cal, srq;
    logic [1:0] bresp, rresp, r;
    logic [31:0] setting;
    integer error_cnt = 0, checked = 0, aborts = 0, a0;
    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (abort === 1'b1) aborts <= aborts + 1;
    ssr_ops_model u_ops (.clk_sys(clk_sys), .busy(busy), .ops_done_pin(ops_done));
    ssr_top uut (.clk_sys(clk_sys), .srst(srst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .config_switch_pin(cfg),
        .ops_done_pin(ops_done), .trigger_abort_reg(abort), .cal_mode_reg(cal), .srq_reg(srq),
        .setting_out_reg(setting));
    task automatic chk(input [31:0] got, input [31:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp)
            begin
                error_cnt = error_cnt + 1;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task automatic wr(input [7:0] a, input [31:0] v, output [1:0] rs);
        begin
            @(posedge clk_sys);
            awaddr <= a;
            wdata <= v;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            do
            begin
                @(posedge clk_sys);
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
                if (bvalid)
                begin
                    rs = bresp;
                    bready <= 1'b0;
                end
            end
            while (bready);
        end
    endtask
    task automatic rd(input [7:0] a, output [31:0] v, output [1:0] rs);
        begin
            @(posedge clk_sys);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            do
            begin
                @(posedge clk_sys);
                if (arready) arvalid <= 1'b0;
                if (rvalid)
                begin
                    v = rdata;
                    rs = rresp;
                    rready <= 1'b0;
                end
            end
            while (rready);
        end
    endtask
    task automatic wait_idle;
        begin
            d = 32'h0;
            while (d[3:0] !== 4'h1) rd(`SSR_OFF_STATUS, d, r);
        end
    endtask
    task automatic cmd(input [3:0] c);
        begin
            wr(`SSR_OFF_CMD, {28'h0, c}, r);
            wait_idle;
        end
    endtask
    task automatic do_reset;
        begin
            @(posedge clk_sys);
            srst <= 1'b1;
            repeat (6) @(posedge clk_sys);
            srst <= 1'b0;
            wait_idle;
        end
    endtask
    task automatic tally_and_finish;
        begin
            $display("checked=%0d error_cnt=%0d", checked, error_cnt);
            if (error_cnt == 0 && checked > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    initial
    begin
        #400000;
        error_cnt = error_cnt + 1;
        tally_and_finish;
    end
    initial
    begin
        do_reset;
        rd(`SSR_OFF_OPTIONS, d, r);
        chk(d, 32'h0);
        cmd(`SSR_CMD_RST);
        rd(`SSR_OFF_SETTING, d, r);
        chk(d, `SSR_RST_SETTING);
        wr(`SSR_OFF_SNAP_DATA, 32'h1, r);
        chk({31'h0, cal}, 32'h1);
        wr(`SSR_OFF_CMD_ARG, 32'h9, r);
        cmd(`SSR_CMD_SAV);
        a0 = aborts;
        wr(`SSR_OFF_CMD_ARG, 32'h9, r);
        cmd(`SSR_CMD_RCL);
        chk({31'h0, cal}, 32'h0);
        chk(aborts - a0, 1);
        rd(`SSR_OFF_SETTING, d, r);
        chk(d, `SSR_RST_SETTING);
        chk(setting, `SSR_RST_SETTING);
        busy <= 1'b1;
        wr(`SSR_OFF_SETTING, 32'h5, r);
        wr(`SSR_OFF_CMD, {28'h0, `SSR_CMD_OPCQ}, r);
        wr(`SSR_OFF_CMD, {28'h0, `SSR_CMD_RST}, r);
        repeat (20) @(posedge clk_sys);
        rd(`SSR_OFF_OUTQ, d, r);
        chk(d & 32'h100, 32'h0);
        rd(`SSR_OFF_SETTING, d, r);
        chk(d, 32'h5);
        busy <= 1'b0;
        wait_idle;
        rd(`SSR_OFF_OUTQ, d, r);
        chk(d, 32'h131);
        rd(`SSR_OFF_SETTING, d, r);
        chk(d, `SSR_RST_SETTING);
        busy <= 1'b1;
        wr(`SSR_OFF_CMD, {28'h0, `SSR_CMD_OPCQ}, r);
        wr(`SSR_OFF_CMD, {28'h0, `SSR_CMD_TRG}, r);
        busy <= 1'b0;
        repeat (8) @(posedge clk_sys);
        rd(`SSR_OFF_STATUS, d, r);
        chk(d & 32'hf, 32'h4);
        cmd(`SSR_CMD_DCL);
        chk(d & 32'hf, 32'h1);
        wr(`SSR_OFF_OUTQ, 32'h0, r);
        wr(`SSR_OFF_SRE, 32'h0, r);
        wr(`SSR_OFF_INPUTS, 32'h10, r);
        chk({31'h0, srq}, 32'h0);
        rd(`SSR_OFF_STB, d, r);
        chk(d, 32'h80);
        wr(`SSR_OFF_SRE, 32'h80, r);
        rd(`SSR_OFF_STB, d, r);
        chk(d, 32'hc0);
        chk({31'h0, srq}, 32'h1);
        cmd(`SSR_CMD_SPOLL);
        chk({31'h0, srq}, 32'h0);
        rd(`SSR_OFF_STB, d, r);
        chk(d, 32'hc0);
        wr(`SSR_OFF_SETTING, 32'h77, r);
        wr(`SSR_OFF_CMD_ARG, 32'h0, r);
        cmd(`SSR_CMD_SAV);
        wr(`SSR_OFF_PSC, 32'h0, r);
        wr(`SSR_OFF_SRE, 32'h20, r);
        wr(`SSR_OFF_ESE, 32'h5, r);
        wr(`SSR_OFF_INPUTS, 32'h0, r);
        do_reset;
        rd(`SSR_OFF_SRE, d, r);
        chk(d, 32'h20);
        rd(`SSR_OFF_ESE, d, r);
        chk(d, 32'h5);
        wr(`SSR_OFF_CMD_ARG, 32'h9, r);
        cmd(`SSR_CMD_RCL);
        rd(`SSR_OFF_SETTING, d, r);
        chk(d, 32'h77);
        wr(`SSR_OFF_PSC, 32'h1, r);
        do_reset;
        rd(`SSR_OFF_SRE, d, r);
        chk(d, 32'h0);
        rd(8'h3c, d, r);
        chk({30'h0, r}, 32'h2);
        wr(8'h41, 32'h5, r);
        chk({30'h0, r}, 32'h2);
        tally_and_finish;
    end
endmodule
